// >>> core/dpc_pkg.sv
package dpc_pkg;
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned CNT_W = 19;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_LF_SEL_A = 8'h76;
    localparam logic [7:0] IDX_CAL_WAIT_A = 8'h77;
    localparam logic [7:0] IDX_CAL_EXT_A = 8'h78;
    localparam logic [7:0] IDX_CAL_CMD_A = 8'h79;
    localparam logic [7:0] IDX_CAL_STAT_A = 8'h7a;
    localparam logic [7:0] IDX_PUMP_W_B = 8'h83;
    localparam logic [7:0] IDX_LF_SEL_B = 8'h84;

    // field positions
    localparam int unsigned LF_SEL_LSB = 0;
    localparam int unsigned LF_SEL_W = 3;
    localparam int unsigned VCO_SEL_LSB = 0;
    localparam int unsigned CLSD_SEL_LSB = 2;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned EXT_BIT = 0;
    localparam int unsigned PUMP_BIT = 7;
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_PHASE_LSB = 1;
    localparam int unsigned STAT_DONE_BIT = 3;

    // reset values
    localparam logic [2:0] LF_SEL_RST = 3'h3;
    localparam logic [1:0] VCO_SEL_RST = 2'h1;
    localparam logic [1:0] CLSD_SEL_RST = 2'h0;
    localparam logic EXT_RST = 1'b0;
    localparam logic PUMP_RST = 1'b0;

    // loop filter codes
    localparam logic [2:0] LF_SECOND_ORDER = 3'h3;
    localparam logic [2:0] LF_THIRD_ORDER = 3'h7;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // always-on time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYCLES = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // settle times in microseconds
    localparam int unsigned CLSD_T0_US = 30;
    localparam int unsigned CLSD_T1_US = 300;
    localparam int unsigned CLSD_T2_US = 30000;
    localparam int unsigned CLSD_T3_US = 300000;
    localparam int unsigned VCO_T0_US = 20;
    localparam int unsigned VCO_T1_US = 400;
    localparam int unsigned VCO_T2_US = 8000;
    localparam int unsigned VCO_T3_US = 200000;
    localparam int unsigned EXT_T_US = 60000;

    // settle times in ticks
    localparam int unsigned CLSD_T0_TK = CLSD_T0_US / TICK_US;
    localparam int unsigned CLSD_T1_TK = CLSD_T1_US / TICK_US;
    localparam int unsigned CLSD_T2_TK = CLSD_T2_US / TICK_US;
    localparam int unsigned CLSD_T3_TK = CLSD_T3_US / TICK_US;
    localparam int unsigned VCO_T0_TK = VCO_T0_US / TICK_US;
    localparam int unsigned VCO_T1_TK = VCO_T1_US / TICK_US;
    localparam int unsigned VCO_T2_TK = VCO_T2_US / TICK_US;
    localparam int unsigned VCO_T3_TK = VCO_T3_US / TICK_US;
    localparam int unsigned EXT_T_TK = EXT_T_US / TICK_US;

    // calibration phases
    typedef enum logic [1:0] {
        DPC_IDLE = 2'b00,
        DPC_EXTEND = 2'b01,
        DPC_VCO = 2'b10,
        DPC_CLOSED = 2'b11
    } dpc_phase_t;
endpackage : dpc_pkg

// >>> core/dpc_cal_timer.sv
module dpc_cal_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic start,
    input wire logic extend_en,
    input wire logic [18:0] ext_ticks,
    input wire logic [18:0] vco_ticks,
    input wire logic [18:0] clsd_ticks,
    output logic busy,
    output logic [1:0] phase,
    output logic done
);
    dpc_pkg::dpc_phase_t state_r;
    logic [18:0] cnt_r;
    logic [18:0] vco_r;
    logic [18:0] clsd_r;
    logic last;

    assign last = tick && (cnt_r <= 19'h00001);

    // sequence: optional extra delay, vco wait, closed-loop wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= dpc_pkg::DPC_IDLE;
            cnt_r <= 19'h00000;
            vco_r <= 19'h00000;
            clsd_r <= 19'h00000;
        end else begin
            case (state_r)
                dpc_pkg::DPC_IDLE: begin
                    if (start) begin
                        vco_r <= vco_ticks;
                        clsd_r <= clsd_ticks;
                        if (extend_en) begin
                            state_r <= dpc_pkg::DPC_EXTEND;
                            cnt_r <= ext_ticks;
                        end else begin
                            state_r <= dpc_pkg::DPC_VCO;
                            cnt_r <= vco_ticks;
                        end
                    end
                end
                dpc_pkg::DPC_EXTEND: begin
                    if (last) begin
                        state_r <= dpc_pkg::DPC_VCO;
                        cnt_r <= vco_r;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 19'h00001;
                    end
                end
                dpc_pkg::DPC_VCO: begin
                    if (last) begin
                        state_r <= dpc_pkg::DPC_CLOSED;
                        cnt_r <= clsd_r;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 19'h00001;
                    end
                end
                dpc_pkg::DPC_CLOSED: begin
                    if (last) begin
                        state_r <= dpc_pkg::DPC_IDLE;
                        cnt_r <= 19'h00000;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 19'h00001;
                    end
                end
                default: begin
                    state_r <= dpc_pkg::DPC_IDLE;
                end
            endcase
        end
    end

    // status towards the register file
    assign busy = (state_r != dpc_pkg::DPC_IDLE);
    assign phase = state_r;
    assign done = (state_r == dpc_pkg::DPC_CLOSED) && last;
endmodule : dpc_cal_timer

// >>> core/dpc_regs.sv
// Operation
// - loop filter code 3 selects second order, code 7 third order
// - closed-loop wait codes give 30us, 300us, 30ms, 300ms
// - vco wait codes give 20us, 400us, 8ms, 200ms
// - extend bit set delays vco calibration by an extra 60ms
// - pump widen bit: 0 gives 200ps pulse, 1 gives about 600ps
module dpc_regs #(
    parameter int unsigned VCO_T2_TICKS = dpc_pkg::VCO_T2_TK,
    parameter int unsigned VCO_T3_TICKS = dpc_pkg::VCO_T3_TK,
    parameter int unsigned CLSD_T2_TICKS = dpc_pkg::CLSD_T2_TK,
    parameter int unsigned CLSD_T3_TICKS = dpc_pkg::CLSD_T3_TK,
    parameter int unsigned EXT_TICKS = dpc_pkg::EXT_T_TK
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] loop_filter_order_sel_a,
    output logic loop_filter_second_a,
    output logic loop_filter_third_a,
    output logic [2:0] loop_filter_order_sel_b,
    output logic loop_filter_second_b,
    output logic loop_filter_third_b,
    output logic [1:0] vco_settle_sel,
    output logic [1:0] closed_loop_settle_sel,
    output logic cal_delay_extend_a,
    output logic pump_pulse_widen_b,
    output logic cal_busy_a,
    output logic cal_done_a
);
    // register state
    logic [2:0] lf_sel_a_r;
    logic [2:0] lf_sel_b_r;
    logic [1:0] vco_sel_r;
    logic [1:0] clsd_sel_r;
    logic ext_a_r;
    logic pump_b_r;
    logic done_a_r;

    // write channel state
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_idx_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_fire;

    // read channel state
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // time base and timer wiring
    logic [6:0] div_r;
    logic tick;
    logic cal_start;
    logic cal_busy;
    logic [1:0] cal_phase;
    logic cal_done;

    // register index from byte address
    function automatic logic [7:0] addr_to_idx(input logic [11:0] addr);
        addr_to_idx = addr[9:2];
    endfunction : addr_to_idx

    // known register index test
    function automatic logic idx_known(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        idx_known = (addr[11:10] == 2'h0) && ((idx == dpc_pkg::IDX_LF_SEL_A) ||
            (idx == dpc_pkg::IDX_CAL_WAIT_A) || (idx == dpc_pkg::IDX_CAL_EXT_A) ||
            (idx == dpc_pkg::IDX_CAL_CMD_A) || (idx == dpc_pkg::IDX_CAL_STAT_A) ||
            (idx == dpc_pkg::IDX_PUMP_W_B) || (idx == dpc_pkg::IDX_LF_SEL_B));
    endfunction : idx_known

    // closed-loop wait code to tick count
    function automatic logic [18:0] clsd_len(input logic [1:0] sel);
        case (sel)
            2'h0: clsd_len = 19'(dpc_pkg::CLSD_T0_TK);
            2'h1: clsd_len = 19'(dpc_pkg::CLSD_T1_TK);
            2'h2: clsd_len = 19'(CLSD_T2_TICKS);
            default: clsd_len = 19'(CLSD_T3_TICKS);
        endcase
    endfunction : clsd_len

    // vco wait code to tick count
    function automatic logic [18:0] vco_len(input logic [1:0] sel);
        case (sel)
            2'h0: vco_len = 19'(dpc_pkg::VCO_T0_TK);
            2'h1: vco_len = 19'(dpc_pkg::VCO_T1_TK);
            2'h2: vco_len = 19'(VCO_T2_TICKS);
            default: vco_len = 19'(VCO_T3_TICKS);
        endcase
    endfunction : vco_len

    // axi handshake outputs
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // write commits once address and data are both held
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

    // hold write address and data, accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_idx_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_idx_r <= idx_known(s_axi_awaddr) ? addr_to_idx(s_axi_awaddr) : 8'h00;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response, slave error for an unmapped index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= dpc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_idx_r == 8'h00) ? dpc_pkg::RESP_SLVERR : dpc_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // register writes, only the low byte lane carries fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_sel_a_r <= dpc_pkg::LF_SEL_RST;
            lf_sel_b_r <= dpc_pkg::LF_SEL_RST;
            vco_sel_r <= dpc_pkg::VCO_SEL_RST;
            clsd_sel_r <= dpc_pkg::CLSD_SEL_RST;
            ext_a_r <= dpc_pkg::EXT_RST;
            pump_b_r <= dpc_pkg::PUMP_RST;
        end else if (wr_fire && wstrb_r[0]) begin
            case (aw_idx_r)
                dpc_pkg::IDX_LF_SEL_A: begin
                    lf_sel_a_r <= wdata_r[dpc_pkg::LF_SEL_LSB +: dpc_pkg::LF_SEL_W];
                end
                dpc_pkg::IDX_LF_SEL_B: begin
                    lf_sel_b_r <= wdata_r[dpc_pkg::LF_SEL_LSB +: dpc_pkg::LF_SEL_W];
                end
                dpc_pkg::IDX_CAL_WAIT_A: begin
                    vco_sel_r <= wdata_r[dpc_pkg::VCO_SEL_LSB +: dpc_pkg::SEL_W];
                    clsd_sel_r <= wdata_r[dpc_pkg::CLSD_SEL_LSB +: dpc_pkg::SEL_W];
                end
                dpc_pkg::IDX_CAL_EXT_A: begin
                    ext_a_r <= wdata_r[dpc_pkg::EXT_BIT];
                end
                dpc_pkg::IDX_PUMP_W_B: begin
                    pump_b_r <= wdata_r[dpc_pkg::PUMP_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // command write starts a calibration when idle
    assign cal_start = wr_fire && wstrb_r[0] && (aw_idx_r == dpc_pkg::IDX_CAL_CMD_A) &&
        wdata_r[dpc_pkg::CMD_START_BIT] && !cal_busy;

    // done flag: set by the timer, cleared by a new start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_a_r <= 1'b0;
        end else if (cal_done) begin
            done_a_r <= 1'b1;
        end else if (cal_start) begin
            done_a_r <= 1'b0;
        end
    end

    // read path, reserved bits return zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= dpc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= idx_known(s_axi_araddr) ? dpc_pkg::RESP_OKAY : dpc_pkg::RESP_SLVERR;
            rdata_r <= 32'h00000000;
            if (idx_known(s_axi_araddr)) begin
                case (addr_to_idx(s_axi_araddr))
                    dpc_pkg::IDX_LF_SEL_A: begin
                        rdata_r[dpc_pkg::LF_SEL_LSB +: dpc_pkg::LF_SEL_W] <= lf_sel_a_r;
                    end
                    dpc_pkg::IDX_LF_SEL_B: begin
                        rdata_r[dpc_pkg::LF_SEL_LSB +: dpc_pkg::LF_SEL_W] <= lf_sel_b_r;
                    end
                    dpc_pkg::IDX_CAL_WAIT_A: begin
                        rdata_r[dpc_pkg::VCO_SEL_LSB +: dpc_pkg::SEL_W] <= vco_sel_r;
                        rdata_r[dpc_pkg::CLSD_SEL_LSB +: dpc_pkg::SEL_W] <= clsd_sel_r;
                    end
                    dpc_pkg::IDX_CAL_EXT_A: begin
                        rdata_r[dpc_pkg::EXT_BIT] <= ext_a_r;
                    end
                    dpc_pkg::IDX_PUMP_W_B: begin
                        rdata_r[dpc_pkg::PUMP_BIT] <= pump_b_r;
                    end
                    dpc_pkg::IDX_CAL_STAT_A: begin
                        rdata_r[dpc_pkg::STAT_BUSY_BIT] <= cal_busy;
                        rdata_r[dpc_pkg::STAT_PHASE_LSB +: 2] <= cal_phase;
                        rdata_r[dpc_pkg::STAT_DONE_BIT] <= done_a_r;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // microsecond tick standing in for the always-on clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 7'h00;
        end else if (tick) begin
            div_r <= 7'h00;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    assign tick = (div_r == 7'(dpc_pkg::TICK_CYCLES - 1));

    // calibration sequencer for the first synthesizer
    dpc_cal_timer u_cal_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .start(cal_start),
        .extend_en(ext_a_r),
        .ext_ticks(19'(EXT_TICKS)),
        .vco_ticks(vco_len(vco_sel_r)),
        .clsd_ticks(clsd_len(clsd_sel_r)),
        .busy(cal_busy),
        .phase(cal_phase),
        .done(cal_done)
    );

    // decoded loop filter order, reserved codes select neither
    assign loop_filter_second_a = (lf_sel_a_r == dpc_pkg::LF_SECOND_ORDER);
    assign loop_filter_third_a = (lf_sel_a_r == dpc_pkg::LF_THIRD_ORDER);
    assign loop_filter_second_b = (lf_sel_b_r == dpc_pkg::LF_SECOND_ORDER);
    assign loop_filter_third_b = (lf_sel_b_r == dpc_pkg::LF_THIRD_ORDER);

    // settings towards the analog loops
    assign loop_filter_order_sel_a = lf_sel_a_r;
    assign loop_filter_order_sel_b = lf_sel_b_r;
    assign vco_settle_sel = vco_sel_r;
    assign closed_loop_settle_sel = clsd_sel_r;
    assign cal_delay_extend_a = ext_a_r;
    assign pump_pulse_widen_b = pump_b_r;
    assign cal_busy_a = cal_busy;
    assign cal_done_a = done_a_r;
endmodule : dpc_regs

// >>> test/dpc_regs_properties.sv
module dpc_regs_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] loop_filter_order_sel_a,
    input wire logic loop_filter_second_a,
    input wire logic loop_filter_third_a,
    input wire logic [2:0] loop_filter_order_sel_b,
    input wire logic loop_filter_second_b,
    input wire logic loop_filter_third_b,
    input wire logic [1:0] vco_settle_sel,
    input wire logic [1:0] closed_loop_settle_sel,
    input wire logic cal_delay_extend_a,
    input wire logic pump_pulse_widen_b,
    input wire logic cal_busy_a,
    input wire logic cal_done_a
);
    logic [11:0] cfg;

    // all stored settings in one vector
    assign cfg = {loop_filter_order_sel_a, vco_settle_sel, closed_loop_settle_sel, cal_delay_extend_a,
                  pump_pulse_widen_b, loop_filter_order_sel_b};

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both halves of a write taken in one cycle
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    lf_decode_a_a: assert property (
        loop_filter_second_a == (loop_filter_order_sel_a == 3'h3) &&
        loop_filter_third_a == (loop_filter_order_sel_a == 3'h7)) else $error("loop filter a decode wrong");
    lf_decode_b_a: assert property (
        loop_filter_second_b == (loop_filter_order_sel_b == 3'h3) &&
        loop_filter_third_b == (loop_filter_order_sel_b == 3'h7)) else $error("loop filter b decode wrong");
    reset_vals_a: assert property (
        $rose(aresetn) |-> cfg == {3'h3, 2'h1, 2'h0, 1'b0, 1'b0, 3'h3} && !cal_busy_a && !cal_done_a)
        else $error("settings not at reset values");
    cfg_commit_a: assert property (
        !$stable(cfg) |-> $rose(s_axi_bvalid)) else $error("setting changed without a write commit");
    write_resp_a: assert property (
        aw_w_taken |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
    b_hold_a: assert property (
        b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data missing");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    ar_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while data pending");
    busy_min_a: assert property (
        $rose(cal_busy_a) |-> cal_busy_a [*8]) else $error("calibration ended too soon");
    done_end_a: assert property (
        $rose(cal_done_a) |-> ##[0:2] !cal_busy_a) else $error("done raised while still busy");
endmodule : dpc_regs_props

bind dpc_regs dpc_regs_props u_dpc_props (.*);

// >>> test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VT2 = 6, VT3 = 7, CT2 = 8, CT3 = 9, EXT = 5;
    typedef struct packed {logic [7:0] idx; logic [31:0] wd; logic [3:0] st;
        logic [31:0] rd; logic [1:0] rs;} dpc_row_t;
    typedef struct packed {logic [31:0] w; logic [31:0] e; int s; int k;} dpc_cal_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, vco_settle_sel, closed_loop_settle_sel;
    logic [31:0] s_axi_rdata, d;
    logic [2:0] loop_filter_order_sel_a, loop_filter_order_sel_b;
    logic loop_filter_second_a, loop_filter_third_a, loop_filter_second_b, loop_filter_third_b;
    logic cal_delay_extend_a, pump_pulse_widen_b, cal_busy_a, cal_done_a;
    logic [1:0] rs;
    int num_errors = 0, n_compared = 0, cyc = 0, bcnt = 0, c0 = 0, n = 0;
    logic [7:0] rst_idx [5] = '{8'h76, 8'h77, 8'h78, 8'h83, 8'h84};
    logic [31:0] rst_val [5] = '{32'h3, 32'h1, 32'h0, 32'h0, 32'h3};
    dpc_row_t rows [10] = '{
        '{8'h76, 32'hffffff03, 4'hf, 32'h03, 2'h0}, '{8'h76, 32'h07, 4'hf, 32'h07, 2'h0},
        '{8'h77, 32'hfffffff0, 4'hf, 32'h00, 2'h0}, '{8'h77, 32'h0d, 4'hf, 32'h0d, 2'h0},
        '{8'h78, 32'hffffffff, 4'hf, 32'h01, 2'h0}, '{8'h83, 32'hffffff7f, 4'hf, 32'h00, 2'h0},
        '{8'h83, 32'h80, 4'hf, 32'h80, 2'h0}, '{8'h84, 32'h07, 4'hf, 32'h07, 2'h0},
        '{8'h84, 32'h03, 4'he, 32'h07, 2'h0}, '{8'h40, 32'h01, 4'hf, 32'h00, 2'h2}};
    dpc_cal_t cals [3] = '{'{32'h0, 32'h1, EXT + 50, 3}, '{32'ha, 32'h0, VT2 + CT2, 2},
        '{32'hf, 32'h0, VT3 + CT3, 2}};

    dpc_regs #(.VCO_T2_TICKS(VT2), .VCO_T3_TICKS(VT3), .CLSD_T2_TICKS(CT2), .CLSD_T3_TICKS(CT3),
        .EXT_TICKS(EXT)) dut (.*);

    // clock, busy cycle count and hang guard
    always #5 aclk = ~aclk;
    always @(posedge aclk) bcnt <= bcnt + int'(cal_busy_a === 1'b1);
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    // write one word; bready raised only once the response is seen
    task automatic axi_wr(input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st, output logic [1:0] r);
        logic a, w, v, b;
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= wd;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            v = s_axi_bvalid;
            b = v && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            s_axi_bready <= v && !b;
        end
    endtask : axi_wr

    // read one word; rready raised only once the data is seen
    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] q, output logic [1:0] r);
        logic a, v, t;
        @(posedge aclk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge aclk);
            a = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            t = v && s_axi_rready;
            q = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'b0;
            s_axi_rready <= v && !t;
        end
    endtask : axi_rd

    function automatic logic [31:0] outs();
        return {14'h0, loop_filter_order_sel_a, loop_filter_second_a, loop_filter_third_a, loop_filter_order_sel_b,
            loop_filter_second_b, loop_filter_third_b, vco_settle_sel, closed_loop_settle_sel, cal_delay_extend_a,
            pump_pulse_widen_b, cal_busy_a, cal_done_a};
    endfunction : outs

    // main sequence
    initial begin
        do_reset();
        @(posedge aclk);
        chk(outs(), {14'h0, 3'h3, 2'b10, 3'h3, 2'b10, 2'h1, 2'h0, 4'h0});
        for (int i = 0; i < 5; i++) begin
            axi_rd(rst_idx[i], d, rs);
            chk(d, rst_val[i]);
        end
        foreach (rows[i]) begin
            axi_wr(rows[i].idx, rows[i].wd, rows[i].st, rs);
            chk(32'(rs), 32'(rows[i].rs));
            axi_rd(rows[i].idx, d, rs);
            chk(d, rows[i].rd);
            chk(32'(rs), 32'(rows[i].rs));
        end
        chk(outs(), {14'h0, 3'h7, 2'b01, 3'h7, 2'b01, 2'h1, 2'h3, 4'hc});
        // calibration runs, with a start refused while busy
        foreach (cals[i]) begin
            axi_wr(8'h77, cals[i].w, 4'hf, rs);
            axi_wr(8'h78, cals[i].e, 4'hf, rs);
            c0 = bcnt;
            axi_wr(8'h79, 32'h1, 4'hf, rs);
            axi_rd(8'h7a, d, rs);
            chk(d, cals[i].e[0] ? 32'h3 : 32'h5);
            // a restart accepted this late would stretch the busy time past its limit
            repeat (300) @(posedge aclk);
            axi_wr(8'h79, 32'h1, 4'hf, rs);
            while (cal_busy_a !== 1'b0) @(posedge aclk);
            @(posedge aclk);
            n = bcnt - c0;
            chk(32'(n >= (cals[i].s - cals[i].k) * 100 - 3 && n <= cals[i].s * 100 + 5), 32'h1);
            chk(32'(cal_done_a), 32'h1);
            axi_rd(8'h7a, d, rs);
            chk(d, 32'h8);
        end
        do_reset();
        @(posedge aclk);
        chk(outs(), {14'h0, 3'h3, 2'b10, 3'h3, 2'b10, 2'h1, 2'h0, 4'h0});
        wrap_up();
    end
endmodule : tb_top
